// ==== hb16_far_side.sv ====
// Far-side model: address latch plus a peripheral answering reads
`timescale 1ns/1ps
module hb16_far_side
  import hb16_mux_pkg::*;
#(
  parameter logic [15:0] READ_WORD = 16'hc3a5
)
(
  // Port pins and observations
  input  wire logic                i_clk, i_oe, i_ale, i_rd_n, i_wr_n,
  input  wire logic [SHARED_W-1:0] i_ad,
  input  wire logic [UPPER_W-1:0]  i_up,
  output logic      [SHARED_W-1:0] o_bus, o_wdat,
  output logic      [ADDR_W-1:0]   o_lat
);
  logic [SHARED_W-1:0] flip = 16'h0;
  // No pull on the lines, so an undriven bus flips every cycle
  assign o_bus = i_oe ? i_ad : (!i_rd_n ? READ_WORD : flip);
  always @(posedge i_clk)
  begin
    flip <= ~o_bus;
    if (i_ale) o_lat <= {i_up, i_ad};
    if (!i_wr_n) o_wdat <= o_bus;
  end
endmodule

// ==== hb16_mux_pkg.sv ====
// Package: constants for the wide host bus multiplexed port
package hb16_mux_pkg;
  localparam logic [1:0] PORT_MODE_WIDE_HB = 2'h3;   // Main config mode field value
  localparam logic [1:0] HB_MODE_MUXED     = 2'h0;   // Wide config mode field value
  localparam logic       BYTE_LANE_SELECT_OMIT         = 1'h1;   // Byte selects absent when set
  localparam logic [1:0] SEL_LATCH_ONLY    = 2'h0;
  localparam logic [1:0] SEL_ONE_CS        = 2'h1;
  localparam logic [1:0] SEL_TWO_CS        = 2'h2;
  localparam logic [1:0] SEL_LATCH_TWO_CS  = 2'h3;
  localparam int         SHARED_W          = 16;     // Shared address/data lines
  localparam int         ADDR_W            = 28;     // Total address bits out
  localparam int         CS_ADDR_BIT       = 27;     // Address bit picking CS1 over CS0
  localparam logic [2:0] PHASE_CYCLES      = 3'h2;   // Cycles per phase
  localparam logic [2:0] PHASE_LAST        = PHASE_CYCLES - 3'h1;
  localparam int         UPPER_W           = ADDR_W - SHARED_W;
endpackage

// ==== hb16_mux_port.sv ====
// Wide host bus master, multiplexed address/data variant
`timescale 1ns/1ps
module hb16_mux_port
  import hb16_mux_pkg::*;
(
  // Clock and reset
  input  wire logic                          i_clk,
  input  wire logic                          i_resetn,
  // Configuration fields
  input  wire logic [1:0]                    i_port_mode,
  input  wire logic [1:0]                    i_wide_mode,
  input  wire logic                          i_byte_sel_omit,
  input  wire logic [1:0]                    i_sel_arrange,
  // Request from the device side
  input  wire logic                          i_req,
  input  wire logic                          i_req_write,
  input  wire logic [hb16_mux_pkg::ADDR_W-1:0]   i_req_addr,
  input  wire logic [hb16_mux_pkg::SHARED_W-1:0] i_req_wdata,
  input  wire logic [1:0]                    i_req_lanes,
  output logic                               o_req_ready,
  output logic                               o_rd_valid,
  output logic [hb16_mux_pkg::SHARED_W-1:0]  o_rd_data,
  // Shared address/data lines
  input  wire logic [hb16_mux_pkg::SHARED_W-1:0] i_ad,
  output logic [hb16_mux_pkg::SHARED_W-1:0]  o_ad,
  output logic                               o_ad_oe,
  // Upper address lines, address latch enable (active high) and strobes (active low)
  output logic [hb16_mux_pkg::UPPER_W-1:0]   o_upper_addr,
  output logic                               o_ale,
  output logic                               o_rd_n,
  output logic                               o_wr_n,
  output logic [1:0]                         o_cs_n,
  output logic [1:0]                         o_byte_lane_sel_n
);
  typedef enum logic [3:0] {
    ST_IDLE = 4'h1,
    ST_ADDR = 4'h2,
    ST_DATA = 4'h4,
    ST_DONE = 4'h8
  } state_t;

  state_t                 state_reg, state_next;
  logic [2:0]             cnt_reg, cnt_next;
  logic                   wr_reg, wr_next;
  logic [ADDR_W-1:0]      addr_reg, addr_next;
  logic [SHARED_W-1:0]    wdata_reg, wdata_next;
  logic [1:0]             lanes_reg, lanes_next;
  logic [SHARED_W-1:0]    ad_sync1_reg, ad_sync2_reg;
  logic                   ready_next, rvalid_next;
  logic [SHARED_W-1:0]    rdata_next, ad_next;
  logic                   ad_oe_next, ale_next, rd_n_next, wr_n_next;
  logic [1:0]             cs_n_next, byte_lane_select_n_next;
  logic [UPPER_W-1:0]     upper_next;
  logic                   enabled;

  // Chip select lines for the arrangement; only the addressed one goes low
  function automatic logic [1:0] cs_decode(input logic [1:0] arr, input logic hi);
    case (arr)
      SEL_ONE_CS:       cs_decode = 2'h2;
      SEL_TWO_CS,
      SEL_LATCH_TWO_CS: cs_decode = hi ? 2'h1 : 2'h2;
      default:          cs_decode = 2'h3;
    endcase
  endfunction

  // Port is live only in wide host bus, multiplexed
  assign enabled = (i_port_mode == PORT_MODE_WIDE_HB) &&
                   (i_wide_mode == HB_MODE_MUXED);

  // Read data lines are foreign to our clock, so two stages before use
  always_ff @(posedge i_clk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      ad_sync1_reg <= 16'h0000;
      ad_sync2_reg <= 16'h0000;
    end
    else
    begin
      ad_sync1_reg <= i_ad;
      ad_sync2_reg <= ad_sync1_reg;
    end
  end

  // Sequencer next state; outputs computed here so they leave from flops
  always_comb
  begin
    state_next  = state_reg;
    cnt_next    = cnt_reg;
    wr_next     = wr_reg;
    addr_next   = addr_reg;
    wdata_next  = wdata_reg;
    lanes_next  = lanes_reg;
    ready_next  = 1'b0;
    rvalid_next = 1'b0;
    rdata_next  = o_rd_data;
    ad_next     = o_ad;
    ad_oe_next  = 1'b0;
    ale_next    = 1'b0;
    rd_n_next   = 1'b1;
    wr_n_next   = 1'b1;
    cs_n_next   = 2'h3;
    byte_lane_select_n_next = 2'h3;
    upper_next  = o_upper_addr;
    case (state_reg)
      ST_IDLE:
      begin
        ready_next = enabled;
        if (enabled && o_req_ready && i_req)
        begin
          state_next = ST_ADDR;
          cnt_next   = 3'h0;
          wr_next    = i_req_write;
          addr_next  = i_req_addr;
          wdata_next = i_req_wdata;
          lanes_next = i_req_lanes;
          ready_next = 1'b0;
        end
      end
      ST_ADDR:
      begin
        cnt_next   = cnt_reg + 3'h1;
        ad_next    = addr_reg[SHARED_W-1:0];
        ad_oe_next = 1'b1;
        upper_next = addr_reg[ADDR_W-1:SHARED_W];
        ale_next   = (i_sel_arrange == SEL_LATCH_ONLY ||
                      i_sel_arrange == SEL_LATCH_TWO_CS);
        cs_n_next  = cs_decode(i_sel_arrange, addr_reg[CS_ADDR_BIT]);
        if (cnt_reg == PHASE_LAST)
        begin
          state_next = ST_DATA;
          cnt_next   = 3'h0;
        end
      end
      ST_DATA:
      begin
        cnt_next   = cnt_reg + 3'h1;
        ad_next    = wdata_reg;
        ad_oe_next = wr_reg;                                   // Released for reads
        rd_n_next  = wr_reg;
        wr_n_next  = !wr_reg;
        cs_n_next  = cs_decode(i_sel_arrange, addr_reg[CS_ADDR_BIT]);
        byte_lane_select_n_next = (i_byte_sel_omit == BYTE_LANE_SELECT_OMIT) ? 2'h3 : ~lanes_reg;
        if (cnt_reg == PHASE_LAST)
        begin
          state_next = ST_DONE;
          cnt_next   = 3'h0;
        end
      end
      ST_DONE:
      begin
        // Strobe-time data reaches the second sync stage only on the edge where
        // the strobe rises, so finish a cycle later; costs a cycle per access
        cnt_next = cnt_reg + 3'h1;
        if (cnt_reg != 3'h0)
        begin
          rvalid_next = !wr_reg;
          rdata_next  = wr_reg ? o_rd_data : ad_sync2_reg;
          ready_next  = enabled;
          state_next  = ST_IDLE;
        end
      end
      default:
        state_next = ST_IDLE;
    endcase
  end

  // Registers only
  always_ff @(posedge i_clk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      state_reg         <= ST_IDLE;
      cnt_reg           <= 3'h0;
      wr_reg            <= 1'b0;
      addr_reg          <= '0;
      wdata_reg         <= 16'h0000;
      lanes_reg         <= 2'h0;
      o_req_ready       <= 1'b0;
      o_rd_valid        <= 1'b0;
      o_rd_data         <= 16'h0000;
      o_ad              <= 16'h0000;
      o_ad_oe           <= 1'b0;
      o_upper_addr      <= '0;
      o_ale             <= 1'b0;
      o_rd_n            <= 1'b1;
      o_wr_n            <= 1'b1;
      o_cs_n            <= 2'h3;
      o_byte_lane_sel_n <= 2'h3;
    end
    else
    begin
      state_reg         <= state_next;
      cnt_reg           <= cnt_next;
      wr_reg            <= wr_next;
      addr_reg          <= addr_next;
      wdata_reg         <= wdata_next;
      lanes_reg         <= lanes_next;
      o_req_ready       <= ready_next;
      o_rd_valid        <= rvalid_next;
      o_rd_data         <= rdata_next;
      o_ad              <= ad_next;
      o_ad_oe           <= ad_oe_next;
      o_upper_addr      <= upper_next;
      o_ale             <= ale_next;
      o_rd_n            <= rd_n_next;
      o_wr_n            <= wr_n_next;
      o_cs_n            <= cs_n_next;
      o_byte_lane_sel_n <= byte_lane_select_n_next;
    end
  end
endmodule

// ==== hb16_mux_port_assertions.sv ====
// Checker for the wide host bus multiplexed port
`timescale 1ns/1ps
module hb16_mux_port_assertions
  import hb16_mux_pkg::*;
(
  // Watched ports
  input wire logic       i_clk, i_resetn, i_req, i_byte_sel_omit,
  input wire logic [1:0] i_port_mode, i_wide_mode, i_sel_arrange,
  input wire logic       o_req_ready, o_rd_valid, o_ad_oe, o_ale, o_rd_n, o_wr_n,
  input wire logic [1:0] o_cs_n, o_byte_lane_sel_n
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_resetn);
  // Config is held steady by the bench while an access runs
  wire go = i_req && o_req_ready && i_port_mode == PORT_MODE_WIDE_HB
            && i_wide_mode == HB_MODE_MUXED;
  wire strobe = !o_rd_n || !o_wr_n;
  property p_spacing; go |=> !o_req_ready [*6] ##1 o_req_ready; endproperty
  a_spacing: assert property (p_spacing) else $error("bad spacing");
  property p_ale; $rose(o_ale) |-> o_ad_oe && i_sel_arrange[0] == i_sel_arrange[1]
    ##1 o_ale ##1 !o_ale; endproperty
  a_ale: assert property (p_ale) else $error("bad latch strobe");
  property p_no_ale; go && i_sel_arrange[0] != i_sel_arrange[1] |=> !o_ale [*5]; endproperty
  a_no_ale: assert property (p_no_ale) else $error("stray latch strobe");
  property p_rd_free; !o_rd_n |-> !o_ad_oe && o_wr_n; endproperty
  a_rd_free: assert property (p_rd_free) else $error("read not released");
  property p_wr; $fell(o_wr_n) |-> o_ad_oe ##1 !o_wr_n && o_ad_oe ##1 o_wr_n; endproperty
  a_wr: assert property (p_wr) else $error("bad write phase");
  property p_cs; strobe |-> (i_sel_arrange == SEL_LATCH_ONLY ? o_cs_n == 2'h3
    : $onehot(~o_cs_n)); endproperty
  a_cs: assert property (p_cs) else $error("bad selects");
  property p_omit; strobe && i_byte_sel_omit |-> o_byte_lane_sel_n == 2'h3; endproperty
  a_omit: assert property (p_omit) else $error("lane selects shown");
  property p_rdv; o_rd_valid |-> !$past(o_rd_n, 2) && o_rd_n && !$past(o_rd_valid); endproperty
  a_rdv: assert property (p_rdv) else $error("bad read valid");
endmodule

// ==== test_hb16_mux_port.sv ====
// Testbench for the wide host bus multiplexed port
`timescale 1ns/1ps
module test_hb16_mux_port;
  import hb16_mux_pkg::*;
  logic        clk = 0, rstn = 0, req = 0, wr = 0, omit = 0;
  logic [1:0]  pmode = 2'h3, wmode = 2'h0, arr = 2'h0, lanes = 2'h3;
  logic [27:0] addr = 28'h0;
  logic [15:0] wdat = 16'h0;
  wire         rdy, rdv, oe, ale, rd_n, wr_n;
  wire  [15:0] rdata, ad_o, bus, seen;
  wire  [11:0] up;
  wire  [27:0] lat;
  wire  [1:0]  cs_n, bs_n;
  int          bad_count = 0, comparisons = 0, n;
  always #25 clk = ~clk;
  hb16_mux_port DUT (.i_clk(clk), .i_resetn(rstn), .i_port_mode(pmode), .i_wide_mode(wmode),
    .i_byte_sel_omit(omit), .i_sel_arrange(arr), .i_req(req), .i_req_write(wr),
    .i_req_addr(addr), .i_req_wdata(wdat), .i_req_lanes(lanes), .o_req_ready(rdy),
    .o_rd_valid(rdv), .o_rd_data(rdata), .i_ad(bus), .o_ad(ad_o), .o_ad_oe(oe),
    .o_upper_addr(up), .o_ale(ale), .o_rd_n(rd_n), .o_wr_n(wr_n), .o_cs_n(cs_n),
    .o_byte_lane_sel_n(bs_n));
  hb16_far_side far (.i_clk(clk), .i_oe(oe), .i_ale(ale), .i_rd_n(rd_n), .i_wr_n(wr_n),
    .i_ad(ad_o), .i_up(up), .o_bus(bus), .o_wdat(seen), .o_lat(lat));
  task automatic give_verdict;
    $display("%0d mismatches in %0d comparisons", bad_count, comparisons);
    if (bad_count == 0 && comparisons > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic check(input string what, input logic [27:0] exp, got);
    comparisons++;
    if (exp !== got) $display("unexpected %s: expected %h seen %h", what, exp, got);
    if (exp !== got) bad_count++;
  endtask
  // A wait that used up its bound ends the run
  task automatic waited;
    if (n >= 20) bad_count++;
    if (n >= 20) give_verdict();
  endtask
  // One access; request raised at a falling edge while ready is up
  task automatic xfer(input logic w, input logic [27:0] a, input logic [15:0] d);
    for (n = 0; n < 20 && rdy !== 1'b1; n++) @(negedge clk);
    waited();
    {wr, addr, wdat, req} = {w, a, d, 1'b1};
    @(negedge clk) req = 0;
    for (n = 0; n < 20 && rd_n === 1'b1 && wr_n === 1'b1; n++) @(negedge clk);
    waited();
    check("strobes", w ? 2'h2 : 2'h1, {rd_n, wr_n});
    check("selects", arr == SEL_LATCH_ONLY ? 2'h3 : (arr != SEL_ONE_CS && a[CS_ADDR_BIT])
      ? 2'h1 : 2'h2, cs_n);
    check("lanes", omit ? 2'h3 : 2'(~lanes), bs_n);
    if (arr[0] == arr[1]) check("latched", a, lat);
    for (n = 0; n < 20 && rdv !== 1'b1 && rdy !== 1'b1; n++) @(negedge clk);
    waited();
    check("data", w ? d : 16'hc3a5, w ? seen : rdata);
  endtask
  initial
  begin
    repeat (3) @(negedge clk);
    rstn = 1;
    // Every arrangement, lane selects on and off, back to back
    for (int k = 0; k < 8; k++)
    begin
      {omit, arr, lanes} = {k[2:0], 2'(k % 3 + 1)};
      xfer(1, {k[0], 27'h2b4c1e7 ^ 27'(k)}, 16'h1234 ^ 16'(k));
      xfer(0, {~k[0], 27'h05a3f0c}, 16'h0);
    end
    // Reset in the address phase must drop the latch strobe, drive enable and selects at once
    {wr, addr, req} = {1'b1, 28'h0000abc, 1'b1};
    repeat (3) @(negedge clk);
    {rstn, req} = 2'h0;
    @(negedge clk);
    check("reset", 10'h03f, {rdy, rdv, oe, ale, rd_n, wr_n, cs_n, bs_n});
    rstn = 1;
    // Outside the multiplexed wide mode a request starts nothing
    for (int k = 0; k < 2; k++)
    begin
      {pmode, wmode, req} = k ? 5'h1b : 5'h09;
      repeat (8) @(negedge clk) check("idle", 5'h03, {rdy, oe, ale, rd_n, wr_n});
      {pmode, wmode, req} = 5'h18;
    end
    xfer(0, 28'h8000001, 16'h0);
    give_verdict();
  end
endmodule
bind hb16_mux_port hb16_mux_port_assertions chk (
  .i_clk(i_clk), .i_resetn(i_resetn), .i_req(i_req), .i_byte_sel_omit(i_byte_sel_omit),
  .i_port_mode(i_port_mode), .i_wide_mode(i_wide_mode), .i_sel_arrange(i_sel_arrange),
  .o_req_ready(o_req_ready), .o_rd_valid(o_rd_valid), .o_ad_oe(o_ad_oe), .o_ale(o_ale),
  .o_rd_n(o_rd_n), .o_wr_n(o_wr_n), .o_cs_n(o_cs_n), .o_byte_lane_sel_n(o_byte_lane_sel_n));
